// ==== common/l2bt_consts.svh ====
// Constants for the secondary-cache bus tenure control block.
// Included by the package and the design; holds definitions only.
`ifndef L2BT_CONSTS_SVH
`define L2BT_CONSTS_SVH

// Valid-bit clearing sequence length, in bus clocks
`define L2BT_INIT_CYCLES    4000
// Beats of a burst data tenure
`define L2BT_BURST_BEATS    4
// Width of the clearing index
`define L2BT_IDX_W          12

// Register byte offsets
`define L2BT_CTRL_OFF       12'h000
`define L2BT_STATUS_OFF     12'h004
`define L2BT_CLAIMS_OFF     12'h008

// Control field positions and reset value
`define L2BT_CTRL_FAST_BIT  0
`define L2BT_CTRL_RESET     1'h0

// Status field positions
`define L2BT_ST_INIT_BIT    0
`define L2BT_ST_EN_BIT      1
`define L2BT_ST_SNOOP_BIT   2
`define L2BT_ST_ACK_BIT     3
`define L2BT_ST_PEND_BIT    4
`define L2BT_ST_ACT_BIT     5
`define L2BT_ST_EXT_BIT     6

`endif

// ==== common/l2bt_pkg.sv ====
// Types of the secondary-cache bus tenure control block.
// Assumes the constants header is on the include path.
`include "l2bt_consts.svh"

package l2bt_pkg;

   // Address tenure tracking states
   typedef enum logic [1:0] {AT_IDLE, AT_PEND, AT_WIN} l2bt_at_e;

   // Address phase seen on the bus, fields active high
   typedef struct packed {
      logic ts;
      logic burst;
      logic read;
      logic data;
      logic cpu;
      logic hit;
   } l2bt_addr_s;

   // Shared bus controls seen on the bus, fields active high
   typedef struct packed {
      logic aack;
      logic artry;
      logic ta;
      logic tea;
      logic dbb;
      logic dgrant;
   } l2bt_bus_s;

   // Attributes latched for a tenure
   typedef struct packed {
      logic claim;
      logic data;
      logic burst;
      logic read;
      logic real_dt;
   } l2bt_attr_s;

endpackage : l2bt_pkg

// ==== hw/l2bt_tenure.sv ====
// Bus tenure control of a look-aside secondary cache, with APB registers.
// Assumes bus pins are synchronous to pclk; straps and inhibit are not.
//
// Contract
// [R1] Strap selects whether bridge transactions carry real data tenures.
// [R2] On a claimed hit the device ends the address tenure and drives TA.
// [R3] Claimed request with idle data bus: AACK the cycle after TS.
// [R4] With a data tenure outstanding, AACK waits; at most two outstanding.
// [R5] Acknowledge strap low: device never asserts AACK.
// [R6] Arbiter negates processor grant when two data tenures are outstanding.
// [R7] After reset release, clear all valid bits over 4000 clocks.
// [R8] During clearing, take no part but keep tracking bus tenures.
// [R9] Update inhibit held from reset keeps caching disabled.
// [R10] Master gives TS one cycle and holds attributes until AACK.
// [R11] The AACK driver is slave; device claims only its hits.
// [R12] ARTRY is sampled in the cycle after AACK by all devices.
// [R13] After a retry, non-retrying devices drop requests; else TS may follow.
// [R14] Data tenure starts only after TS and a qualified data grant.
// [R15] Burst completes after four TA, single beat after one.
// [R16] Slave drives reads and asserts TA for every beat.
// [R17] Data bus master holds DBB from grant until tenure end.
// [R18] ARTRY or TEA ends a data tenure early.
// [R19] Turnaround cycle between tenures unless fast-mode read hits stream.
// [R20] Stream when grant coincides with the fourth TA of the first hit.
// [R21] Device acts only on qualified processor data grants.
// [R22] Zero-wait streaming only between read hits of this device.
// [R23] During clearing, claim, AACK and TA stay negated.
`timescale 1ns/1ps
`default_nettype none
`include "l2bt_consts.svh"

module l2bt_tenure #(
   parameter int unsigned INIT_CYCLES = `L2BT_INIT_CYCLES
) (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   output var  logic [31:0]             prdata,
   output var  logic                    pready,
   output var  logic                    pslverr,
   input  wire l2bt_pkg::l2bt_addr_s    addr_in,
   input  wire l2bt_pkg::l2bt_bus_s     bus_in,
   input  wire logic                    snoop_data_tenure_strap,
   input  wire logic                    ack_enable_strap,
   input  wire logic                    cache_update_inhibit,
   output var  logic                    hit_claim_n,
   output var  logic                    aack_n_o,
   output var  logic                    aack_oe,
   output var  logic                    ta_n_o,
   output var  logic                    ta_oe,
   output var  logic                    data_oe,
   output var  logic                    valid_clear,
   output var  logic [`L2BT_IDX_W-1:0]  valid_clear_idx
);
   import l2bt_pkg::*;

   if (INIT_CYCLES < 1 || INIT_CYCLES >= (1 << `L2BT_IDX_W)) begin : g_chk
      $error("INIT_CYCLES out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [2:0]             sy1, sy2, sy3, filt;
   logic                   snoop_strap, ack_en;
   logic                   init_busy;
   logic [`L2BT_IDX_W-1:0] init_cnt;
   logic                   fast_secondary_cache_mode;
   logic [31:0]            claims;
   l2bt_at_e               at_st;
   l2bt_attr_s             at_attr, pa, go_attr;
   logic                   pend, dt_act, dt_burst, dt_read;
   logic [1:0]             beat;
   logic                   ext_out, ext_burst;
   logic [1:0]             ext_beat;
   logic                   enabled, claim_now, free, dt_last, stream, dt_start, early, cut, go_on;

   // Index of the last beat in a tenure of the given kind
   function automatic logic [1:0] last_beat(input logic burst);
      last_beat = burst ? 2'(`L2BT_BURST_BEATS - 1) : 2'h0;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: a rise counts once stages two and three are both high, a fall as soon as they differ
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sy1 <= 3'h7;
         sy2 <= 3'h7;
         sy3 <= 3'h7;
      end else begin
         sy1 <= {cache_update_inhibit, ack_enable_strap, snoop_data_tenure_strap};
         sy2 <= sy1;
         sy3 <= sy2;
      end
   end

   // Filtered levels; inhibit reads as asserted from reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt <= 3'h7;
      end else begin
         filt <= (sy2 & sy3) | (filt & ~(sy2 ^ sy3));
      end
   end

   // Straps caught while clearing runs, frozen afterwards
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         snoop_strap <= 1'b1;
         ack_en      <= 1'b1;
      end else if (init_busy) begin
         snoop_strap <= filt[0]; // see [R1]
         ack_en      <= filt[1]; // see [R5]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Valid-bit clearing sequence after reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_busy <= 1'b1;
         init_cnt  <= '0;
      end else if (init_busy) begin
         init_cnt  <= init_cnt + 1'b1; // see [R7]
         init_busy <= (init_cnt != `L2BT_IDX_W'(INIT_CYCLES - 1));
      end
   end

   // Clear strobe and index toward the tag array
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         valid_clear     <= 1'b0;
         valid_clear_idx <= '0;
      end else begin
         valid_clear     <= init_busy; // see [R7]
         valid_clear_idx <= init_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Claim and acknowledge conditions
   assign enabled   = !init_busy && !filt[2];                      // see [R9] [R23]
   assign claim_now = addr_in.ts && addr_in.cpu && addr_in.hit
                      && addr_in.data && enabled;                  // see [R2] [R11]
   assign dt_last   = dt_act && beat == last_beat(dt_burst);
   assign free      = !pend && !ext_out && !bus_in.dbb
                      && (!dt_act || dt_last);                     // see [R4]

   ////////////////////////////////////////////////////////////////////////
   // Address tenure tracking, runs during clearing too
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         at_st       <= AT_IDLE;
         at_attr     <= '0;
         hit_claim_n <= 1'b1;
         aack_oe     <= 1'b0;
         aack_n_o    <= 1'b1;
      end else begin
         aack_oe  <= 1'b0;
         aack_n_o <= 1'b1;
         unique case (at_st)
            AT_IDLE: begin
               if (addr_in.ts) begin // see [R8] [R10]
                  at_st   <= AT_PEND;
                  at_attr <= '{claim: claim_now, data: addr_in.data,
                               burst: addr_in.burst, read: addr_in.read,
                               real_dt: addr_in.cpu || !snoop_strap}; // see [R1]
                  hit_claim_n <= !claim_now;
                  if (claim_now && ack_en && free) begin
                     aack_oe  <= 1'b1; // see [R3]
                     aack_n_o <= 1'b0;
                  end
               end
            end
            AT_PEND: begin
               if (aack_oe || bus_in.aack) begin
                  at_st <= AT_WIN; // see [R12]
               end else if (at_attr.claim && ack_en && free) begin
                  aack_oe  <= 1'b1; // see [R4] [R5]
                  aack_n_o <= 1'b0;
               end
            end
            AT_WIN: begin
               at_st       <= AT_IDLE; // see [R13]
               hit_claim_n <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pending claimed tenure, created when the retry window passes clean
   assign stream   = dt_last && fast_secondary_cache_mode && dt_read && !pend && !early
                     && at_st == AT_PEND && at_attr.claim && at_attr.data
                     && at_attr.read;                              // see [R19] [R22]
   assign dt_start = ((pend && !dt_act) || stream) && bus_in.dgrant
                     && !bus_in.dbb;                               // see [R14] [R20] [R21]
   assign go_attr  = pend ? pa : at_attr;
   assign cut      = early && at_st == AT_WIN && bus_in.artry;     // see [R18]
   assign go_on    = dt_act && !dt_last && !bus_in.tea && !cut;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend <= 1'b0;
         pa   <= '0;
      end else if (at_st == AT_WIN && !bus_in.artry
                   && at_attr.claim && at_attr.data && !early) begin
         pend <= 1'b1; // see [R12] [R18]
         pa   <= at_attr;
      end else if (dt_start) begin
         pend <= 1'b0;
      end
   end

   // Tenure started by streaming before its retry window passed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         early <= 1'b0;
      end else if (dt_start || at_st == AT_WIN) begin
         early <= dt_start && !pend; // see [R20]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Own data tenure: TA per beat, read data driven, TEA ends it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dt_act   <= 1'b0;
         dt_burst <= 1'b0;
         dt_read  <= 1'b0;
         beat     <= 2'h0;
      end else if (dt_start) begin
         dt_act   <= 1'b1;
         dt_burst <= go_attr.burst; // see [R15]
         dt_read  <= go_attr.read;
         beat     <= 2'h0;
      end else if (dt_act && (bus_in.tea || dt_last || cut)) begin
         dt_act <= 1'b0; // see [R18]
      end else if (dt_act) begin
         beat <= beat + 2'h1;
      end
   end

   // Bus drivers for the tenure, registered in step with dt_act and beat
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ta_oe   <= 1'b0;
         ta_n_o  <= 1'b1;
         data_oe <= 1'b0;
      end else begin
         ta_oe   <= dt_start || go_on; // see [R16]
         ta_n_o  <= !(dt_start || go_on);
         data_oe <= dt_start ? go_attr.read : (go_on && dt_read);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Other slave's tenure: counted by its TA beats until done
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_out   <= 1'b0;
         ext_burst <= 1'b0;
         ext_beat  <= 2'h0;
      end else if (at_st == AT_WIN && !bus_in.artry && !at_attr.claim
                   && at_attr.data && at_attr.real_dt) begin
         ext_out   <= 1'b1; // see [R1] [R4]
         ext_burst <= at_attr.burst;
         ext_beat  <= 2'h0;
      end else if (ext_out && bus_in.tea) begin
         ext_out <= 1'b0; // see [R18]
      end else if (ext_out && bus_in.ta && !ta_oe) begin
         ext_beat <= ext_beat + 2'h1;
         ext_out  <= ext_beat != last_beat(ext_burst); // see [R15]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB: zero-wait slave, unmapped addresses answer with pslverr
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && paddr != `L2BT_CTRL_OFF
                    && paddr != `L2BT_STATUS_OFF && paddr != `L2BT_CLAIMS_OFF;
         prdata  <= 32'h0;
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               `L2BT_CTRL_OFF:   prdata[`L2BT_CTRL_FAST_BIT] <= fast_secondary_cache_mode;
               `L2BT_STATUS_OFF: begin
                  prdata[`L2BT_ST_INIT_BIT]  <= init_busy;
                  prdata[`L2BT_ST_EN_BIT]    <= enabled;
                  prdata[`L2BT_ST_SNOOP_BIT] <= snoop_strap;
                  prdata[`L2BT_ST_ACK_BIT]   <= ack_en;
                  prdata[`L2BT_ST_PEND_BIT]  <= pend;
                  prdata[`L2BT_ST_ACT_BIT]   <= dt_act;
                  prdata[`L2BT_ST_EXT_BIT]   <= ext_out;
               end
               `L2BT_CLAIMS_OFF: prdata <= claims;
               default:          prdata <= 32'h0;
            endcase
         end
      end
   end

   // Control register write at the access edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_secondary_cache_mode <= `L2BT_CTRL_RESET;
      end else if (psel && penable && pready && pwrite && paddr == `L2BT_CTRL_OFF) begin
         fast_secondary_cache_mode <= pwdata[`L2BT_CTRL_FAST_BIT];
      end
   end

   // Count of claimed hits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         claims <= 32'h0;
      end else if (at_st == AT_IDLE && claim_now) begin
         claims <= claims + 32'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_burst_go;
      dt_start && go_attr.burst ##1 (!bus_in.tea && !cut) [*3];
   endsequence

   property p_aack_next;
      at_st == AT_IDLE && claim_now && ack_en && free |=> aack_oe && !aack_n_o;
   endproperty
   a_aack_next: assert property (p_aack_next) else $error("aack late"); // see [R3]

   property p_ack_strap;
      !ack_en |-> !aack_oe;
   endproperty
   a_ack_strap: assert property (p_ack_strap) else $error("aack with strap low"); // see [R5]

   property p_init_quiet;
      init_busy |=> hit_claim_n && !aack_oe && !ta_oe;
   endproperty
   a_init_quiet: assert property (p_init_quiet) else $error("active in init"); // see [R23]

   property p_two_max;
      aack_oe |-> !pend && !ext_out;
   endproperty
   a_two_max: assert property (p_two_max) else $error("third tenure"); // see [R4]

   property p_burst_four;
      s_burst_go |=> ta_oe && $past(ta_oe, 3);
   endproperty
   a_burst_four: assert property (p_burst_four) else $error("burst short"); // see [R15]

   property p_single;
      dt_start && !go_attr.burst ##1 !bus_in.tea |-> ta_oe ##1 (!ta_oe || $past(stream));
   endproperty
   a_single: assert property (p_single) else $error("single beat wrong"); // see [R15]

   property p_gap;
      $past(dt_last) && $past(ta_oe) && ta_oe |-> $past(stream, 2) || $past(stream);
   endproperty
   a_gap: assert property (p_gap) else $error("no turnaround"); // see [R19]

   property p_retry;
      at_st == AT_WIN && bus_in.artry && !pend |=> !pend;
   endproperty
   a_retry: assert property (p_retry) else $error("retried tenure kept"); // see [R18]

   property p_inhibit;
      $fell(hit_claim_n) |-> $past(enabled);
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("claim while disabled"); // see [R9]

   property p_stream;
      stream && bus_in.dgrant && !bus_in.dbb |=> ta_oe;
   endproperty
   a_stream: assert property (p_stream) else $error("stream stalled"); // see [R20]

endmodule // l2bt_tenure

`default_nettype wire

// ==== verification/l2bt_bus_model.sv ====
// Bus partner model: processor master, memory controller, parked arbiter.
// Assumes the tenure block drives AACK and TA; its DBB input is tied low.
`timescale 1ns/1ps
`default_nettype none

module l2bt_bus_model (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 start,
   input  wire l2bt_pkg::l2bt_addr_s attr,
   input  wire logic                 mc_ack,
   input  wire logic                 retry,
   input  wire logic                 tea_req,
   input  wire logic                 grant,
   input  wire logic                 aack_oe,
   input  wire logic                 ta_oe,
   input  wire logic                 hit_claim_n,
   output var  l2bt_pkg::l2bt_addr_s addr_in,
   output var  l2bt_pkg::l2bt_bus_s  bus_in
);
   import l2bt_pkg::*;

   logic       mc_aack;
   logic       mc_own;
   logic       win;
   logic [2:0] mc_beats;
   l2bt_addr_s held;

   ////////////////////////////////////////////////////////////////////////////
   // Master: TS one cycle, attributes until AACK, then lines let go
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_in <= '0;
      end else if (start) begin
         addr_in <= {1'h1, attr[4:0]};
      end else if (bus_in.aack) begin
         addr_in <= {1'h0, ~addr_in[4:0]};  // Released lines show junk
      end else begin
         addr_in.ts <= 1'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory controller: slave of the tenures it acknowledges that the cache does not claim
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {mc_aack, mc_own, win} <= '0;
         mc_beats <= '0;
         held <= '0;
      end else begin
         mc_aack <= addr_in.ts & mc_ack;
         win <= bus_in.aack;
         if (addr_in.ts) begin
            held <= addr_in;
         end
         if (mc_aack) begin
            mc_own <= 1'h1;
         end else if (win) begin
            mc_own <= 1'h0;
         end
         if (win && mc_own && !retry && held.data && hit_claim_n) begin
            mc_beats <= held.burst ? 3'h4 : 3'h1;
         end else if (mc_beats != 3'h0) begin
            mc_beats <= mc_beats - 3'h1;
         end
      end
   end

   // Shared bus levels seen by every device
   always_comb begin
      bus_in.aack   = mc_aack | aack_oe;
      bus_in.artry  = win & retry;
      bus_in.ta     = ta_oe | (mc_beats != 3'h0);
      bus_in.tea    = tea_req & ta_oe;
      bus_in.dbb    = 1'h0;
      bus_in.dgrant = grant;
   end

endmodule // l2bt_bus_model

`default_nettype wire

// ==== verification/tb_l2_cache_bus_tenure_control.sv ====
// Testbench of the secondary-cache bus tenure control block.
// Assumes the package, the design and the bus model compile first.
`timescale 1ns/1ps
`default_nettype none
`include "l2bt_consts.svh"

module tb_l2_cache_bus_tenure_control;
   import l2bt_pkg::*;

   localparam l2bt_addr_s RD4 = 6'h1f;
   localparam l2bt_addr_s RD1 = 6'h0f;

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, claimed;
   logic [11:0] paddr, valid_clear_idx, vc_max;
   logic [31:0] pwdata, prdata, rd;
   logic        snoop, ack, inhib, hit_claim_n, aack_n_o, aack_oe, ta_n_o, ta_oe;
   logic        data_oe, valid_clear, start, mc_ack, retry, tea_req, grant;
   l2bt_addr_s  attr, addr_in;
   l2bt_bus_s   bus_in;
   int          n_fail, cmp_count, cnt, t0, aack_at, n_ta, n_do, n_vc;

   l2bt_tenure #(.INIT_CYCLES(8)) u_l2bt_tenure (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .addr_in(addr_in), .bus_in(bus_in), .snoop_data_tenure_strap(snoop),
      .ack_enable_strap(ack), .cache_update_inhibit(inhib), .hit_claim_n(hit_claim_n),
      .aack_n_o(aack_n_o), .aack_oe(aack_oe), .ta_n_o(ta_n_o), .ta_oe(ta_oe),
      .data_oe(data_oe), .valid_clear(valid_clear), .valid_clear_idx(valid_clear_idx));
   l2bt_bus_model u_l2bt_bus_model (
      .pclk(pclk), .presetn(presetn), .start(start), .attr(attr), .mc_ack(mc_ack),
      .retry(retry), .tea_req(tea_req), .grant(grant), .aack_oe(aack_oe), .ta_oe(ta_oe),
      .hit_claim_n(hit_claim_n), .addr_in(addr_in), .bus_in(bus_in));

   always #25 pclk = ~pclk;

   ////////////////////////////////////////////////////////////////////////////
   // Per-cycle record of the latest address tenure
   always @(negedge pclk) begin
      cnt++;
      if (addr_in.ts === 1'h1) begin
         t0 = cnt;
         aack_at = -1;
         {n_ta, n_do} = '0;
         claimed = 1'h0;
      end
      if (aack_oe === 1'h1 && aack_at < 0) aack_at = cnt - t0;
      if (ta_oe === 1'h1) n_ta++;
      if (data_oe === 1'h1) n_do++;
      if (hit_claim_n === 1'h0) claimed = 1'h1;
      if (valid_clear === 1'h1) begin
         n_vc++;
         if (valid_clear_idx > vc_max) vc_max = valid_clear_idx;
      end
      if (presetn === 1'h1) chk("pins_n", {30'h0, !aack_oe, !ta_oe}, {30'h0, aack_n_o, ta_n_o});
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rd = prdata;
      err = pslverr;
      chk("pready", 32'h1, {31'h0, pready});
      {psel, penable} <= 2'h0;
   endtask

   task automatic issue(input l2bt_addr_s a, input logic m, r, e);
      @(posedge pclk);
      {attr, mc_ack, retry, tea_req, start} <= {a, m, r, e, 1'h1};
      @(posedge pclk);
      start <= 1'h0;
   endtask

   task automatic run_ts(input l2bt_addr_s a, input logic m, r, e);
      issue(a, m, r, e);
      repeat (16) @(posedge pclk);
   endtask

   task automatic res(input logic c, input int a, input logic [3:0] t);
      chk("claim", {31'h0, c}, {31'h0, claimed});
      chk("aack_at", a, aack_at);
      chk("ta_beats", {28'h0, t}, n_ta);
   endtask

   task automatic do_reset(input int wait_n);
      presetn <= 1'h0;
      repeat (12) @(posedge pclk);
      presetn <= 1'h1;
      n_vc = 0;
      vc_max = '0;
      repeat (wait_n) @(posedge pclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Clearing after reset, then a claimed burst read on an idle bus
   task automatic t_init;
      do_reset(0);
      run_ts(RD4, 1'h1, 1'h0, 1'h0);
      res(1'h0, -1, 4'h0);
      chk("clear_len", 32'h8, n_vc);
      chk("clear_idx", 32'h7, {20'h0, vc_max});
      run_ts(RD4, 1'h0, 1'h0, 1'h0);
      res(1'h1, 1, 4'h4);
      chk("data_oe", 32'h4, n_do);
   endtask

   // Register map, read-only status and an unmapped word
   task automatic t_regs;
      apb(1'h0, `L2BT_CTRL_OFF, 32'h0);
      chk("ctrl_rst", 32'h0, rd);
      apb(1'h1, `L2BT_CTRL_OFF, 32'h1);
      apb(1'h0, `L2BT_CTRL_OFF, 32'h0);
      chk("ctrl_rw", 32'h1, rd);
      apb(1'h1, `L2BT_STATUS_OFF, 32'hff);
      apb(1'h0, `L2BT_STATUS_OFF, 32'h0);
      chk("status", 32'he, rd);
      apb(1'h0, 12'hffc, 32'h0);
      chk("unm_err", 32'h1, {31'h0, err});
      chk("unm_data", 32'h0, rd);
      apb(1'h1, `L2BT_CTRL_OFF, 32'h0);
   endtask

   // Single beat, retried and error-ended tenures
   task automatic t_short;
      run_ts(RD1, 1'h0, 1'h0, 1'h0);
      res(1'h1, 1, 4'h1);
      run_ts(RD4, 1'h0, 1'h1, 1'h0);
      res(1'h1, 1, 4'h0);
      run_ts(RD4, 1'h0, 1'h0, 1'h1);
      res(1'h1, 1, 4'h1);
   endtask

   // Hit pipelined on our own burst: AACK held back
   task automatic t_pipe;
      issue(RD4, 1'h0, 1'h0, 1'h0);
      repeat (2) @(posedge pclk);
      run_ts(RD4, 1'h0, 1'h0, 1'h0);
      res(1'h1, 4, 4'h8);
   endtask

   // Fast mode: read hit pipelined on a read hit streams with no gap
   task automatic t_stream;
      apb(1'h1, `L2BT_CTRL_OFF, 32'h1);
      issue(RD4, 1'h0, 1'h0, 1'h0);
      repeat (2) @(posedge pclk);
      issue(RD4, 1'h0, 1'h0, 1'h0);
      repeat (8) @(posedge pclk);
      res(1'h1, 4, 4'h8);
      chk("data_oe", 32'h8, n_do);
      repeat (8) @(posedge pclk);
      apb(1'h1, `L2BT_CTRL_OFF, 32'h0);
   endtask

   // Both straps low: claim shown but no AACK
   task automatic t_ackoff;
      {ack, snoop} <= 2'h0;
      do_reset(12);
      apb(1'h0, `L2BT_STATUS_OFF, 32'h0);
      chk("status_lo", 32'h2, rd);
      run_ts(RD4, 1'h1, 1'h0, 1'h0);
      res(1'h1, -1, 4'h4);
      {ack, snoop} <= 2'h3;
      do_reset(12);
   endtask

   // Update inhibit from reset, then released
   task automatic t_inhib;
      inhib <= 1'h1;
      do_reset(12);
      run_ts(RD4, 1'h1, 1'h0, 1'h0);
      res(1'h0, -1, 4'h0);
      inhib <= 1'h0;
      repeat (6) @(posedge pclk);
      run_ts(RD4, 1'h0, 1'h0, 1'h0);
      res(1'h1, 1, 4'h4);
   endtask

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      pclk = 1'h0;
      presetn = 1'h0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {snoop, ack, inhib, start, mc_ack, retry, tea_req, grant} = 8'hc1;
      attr = '0;
      {n_fail, cmp_count, cnt, t0, n_ta, n_do, n_vc} = '0;
      aack_at = -1;
      {claimed, vc_max} = '0;
      t_init;
      t_regs;
      t_short;
      t_pipe;
      t_stream;
      t_ackoff;
      t_inhib;
      stop_test;
   end

   // Watchdog against a hung handshake
   initial begin
      repeat (4000) @(posedge pclk);
      n_fail++;
      stop_test;
   end

endmodule // tb_l2_cache_bus_tenure_control

`default_nettype wire
